// File: common/adc_ctrl_pkg.sv
// adc_ctrl_pkg: register indices, field positions, reset values, types
// assumes APB word access: byte address = 4 * register index
package adc_ctrl_pkg;
    // register indices (byte address is four times the index)
    localparam logic [15:0] IDX_SC1 = 16'h0010;
    localparam logic [15:0] IDX_SC2 = 16'h0011;
    localparam logic [15:0] IDX_SC3 = 16'h0012;
    localparam logic [15:0] IDX_SC4 = 16'h0013;
    localparam logic [15:0] IDX_RH = 16'h0014;
    localparam logic [15:0] IDX_RL = 16'h0015;
    localparam logic [15:0] IDX_CVH = 16'h0016;
    localparam logic [15:0] IDX_CVL = 16'h0017;
    localparam logic [15:0] IDX_PIN1 = 16'h30ac;
    localparam logic [15:0] IDX_PIN2 = 16'h30ad;
    localparam logic [15:0] IDX_IRQ_STAT = 16'h0040;
    localparam logic [15:0] IDX_IRQ_MASK = 16'h0041;
    // reset values
    localparam logic [7:0] SC1_RST = 8'h1f;
    localparam logic [7:0] SC2_RST = 8'h08;
    localparam logic [7:0] ZERO_RST = 8'h00;
    // first control register fields
    localparam int SC1_DONE_BIT = 7;
    localparam int SC1_IEN_BIT = 6;
    localparam int SC1_CONT_BIT = 5;
    localparam logic [4:0] CH_STOP = 5'h1f;
    // second control register fields
    localparam int SC2_ACT_BIT = 7;
    localparam int SC2_TRG_BIT = 6;
    localparam int SC2_CFE_BIT = 5;
    localparam int SC2_CGT_BIT = 4;
    localparam int SC2_EMPTY_BIT = 3;
    localparam int SC2_FULL_BIT = 2;
    // sticky event bits
    localparam int EV_DONE = 0;
    localparam int EV_ABORT = 1;
    // request to the converter core
    typedef struct packed {
        logic start;
        logic abort;
        logic [4:0] channel;
    } conv_req_t;
    // answer from the converter core
    typedef struct packed {
        logic done;
        logic [11:0] result;
    } conv_rsp_t;
    // conversion sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } conv_state_t;
endpackage : adc_ctrl_pkg

// File: hw/sar_converter_control.sv
// sar_converter_control: APB register file and conversion sequencer
// assumes a converter core that answers start with a one-cycle done
//
// Operation
// - sc1 write aborts, restarts unless channel all ones
// - fifo mode: each write queues channel in order until the queue holds depth entries
// - fifo mode: start only when queue reaches depth
// - all-ones channel flushes queue, halts conversion
// - compare off, no fifo: done flag on every completion
// - compare on: done flag only on true compare
// - fifo mode: done flag after whole set
// - sc1 write or low result read clears done
// - done flag with enable raises interrupt
// - selected channel is routed to converter
// - five-bit channel select, one channel per code
// - continuous mode repeats conversions or sets
// - active flag spans conversion, cleared on end/abort
// - hardware trigger mode starts on trigger edge
//
// Chosen here: the APB slave port.
`timescale 1ns/10ps
module sar_converter_control
    import adc_ctrl_pkg::*;
#(
    parameter int QDEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // converter core
    output conv_req_t conv_req,
    input wire conv_rsp_t conv_rsp,
    input wire logic hw_trigger_input,
    // interrupt
    output logic irq
);
    // registers
    logic [7:0] sc1_reg; // bit7 is done flag
    logic [2:0] sc2_reg; // trigger, compare enable, compare greater
    logic [7:0] sc3_reg;
    logic [7:0] sc4_reg;
    logic [7:0] cvh_reg;
    logic [7:0] cvl_reg;
    logic [7:0] pin1_reg;
    logic [7:0] pin2_reg;
    logic [11:0] result_reg;
    logic [1:0] ev_stat_reg;
    logic [1:0] ev_mask_reg;
    // sequencer state
    conv_state_t state_reg;
    logic [4:0] ch_q [QDEPTH]; // channel queue
    logic [3:0] q_cnt_reg;
    logic [2:0] set_pos_reg;
    logic armed_reg; // start pending
    logic cont_run_reg; // continuous run in progress
    logic set_hit_reg; // a compare was true in this set
    logic hw_prev_reg;
    logic [7:0] rd_mux;

    // address index of a word access
    function automatic logic [15:0] idx_of(input logic [17:0] a);
        idx_of = a[17:2];
    endfunction : idx_of

    // compare of a result against the programmed value
    function automatic logic cmp_true(input logic [11:0] r, input logic [11:0] cv, input logic gt);
        cmp_true = gt ? (r >= cv) : (r < cv);
    endfunction : cmp_true

    // bus strobes
    logic acc, wr_sc1, rd_rl, rd_stat;
    assign acc = psel & penable & pready;
    assign wr_sc1 = acc & pwrite & (idx_of(paddr) == IDX_SC1);
    assign rd_rl = acc & ~pwrite & (idx_of(paddr) == IDX_RL);
    assign rd_stat = acc & ~pwrite & (idx_of(paddr) == IDX_IRQ_STAT);

    // mode decode
    logic [2:0] depth;
    logic fifo_on, hw_mode, cont, ch_stop_wr, hw_edge;
    assign depth = sc4_reg[2:0];
    assign fifo_on = depth != 3'h0;
    assign hw_mode = sc2_reg[2];
    assign cont = sc1_reg[SC1_CONT_BIT];
    assign ch_stop_wr = pwdata[4:0] == CH_STOP;
    assign hw_edge = hw_trigger_input & ~hw_prev_reg;

    // start and completion events
    logic trig_ok, start_now, done_now, set_last, hit, done_set;
    assign trig_ok = ~hw_mode | hw_edge | cont_run_reg | (set_pos_reg != 3'h0);
    assign start_now = armed_reg & trig_ok & (state_reg == ST_IDLE) & ~wr_sc1;
    assign done_now = (state_reg == ST_BUSY) & conv_rsp.done & ~wr_sc1;
    assign set_last = ~fifo_on | (set_pos_reg == depth - 3'h1);
    assign hit = cmp_true(conv_rsp.result, {cvh_reg[3:0], cvl_reg}, sc2_reg[0]);
    // compare gates the flag; a set counts if any member compared true
    assign done_set = done_now & set_last & (~sc2_reg[1] | hit | set_hit_reg);

    // apb answer: one wait state, pready a flop
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
        end
    end

    // read data and error flag taken with pready
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel & penable & ~pready) begin
            prdata <= {24'h00_0000, rd_mux};
            // only a misaligned word access is refused; unmapped reads answer zero
            pslverr <= paddr[1:0] != 2'h0;
        end else begin
            pslverr <= 1'b0;
        end
    end

    // read multiplexer; unmapped reads as zero
    logic map_hit;
    always_comb begin
        map_hit = 1'b1;
        unique case (idx_of(paddr))
            IDX_SC1: rd_mux = sc1_reg;
            IDX_SC2: rd_mux = {state_reg == ST_BUSY, sc2_reg, q_cnt_reg == 4'h0,
                               q_cnt_reg >= {1'b0, depth} && fifo_on, 2'h0};
            IDX_SC3: rd_mux = sc3_reg;
            IDX_SC4: rd_mux = sc4_reg;
            IDX_RH: rd_mux = {4'h0, result_reg[11:8]};
            IDX_RL: rd_mux = result_reg[7:0];
            IDX_CVH: rd_mux = cvh_reg;
            IDX_CVL: rd_mux = cvl_reg;
            IDX_PIN1: rd_mux = pin1_reg;
            IDX_PIN2: rd_mux = pin2_reg;
            IDX_IRQ_STAT: rd_mux = {6'h00, ev_stat_reg};
            IDX_IRQ_MASK: rd_mux = {6'h00, ev_mask_reg};
            default: begin
                rd_mux = 8'h00;
                map_hit = 1'b0;
            end
        endcase
    end

    // plain control registers written by software
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sc2_reg <= SC2_RST[6:4];
            sc3_reg <= ZERO_RST;
            sc4_reg <= ZERO_RST;
            cvh_reg <= ZERO_RST;
            cvl_reg <= ZERO_RST;
            pin1_reg <= ZERO_RST;
            pin2_reg <= ZERO_RST;
            ev_mask_reg <= 2'h0;
        end else if (acc & pwrite & (paddr[1:0] == 2'h0)) begin
            unique case (idx_of(paddr))
                IDX_SC2: sc2_reg <= pwdata[6:4];
                IDX_SC3: sc3_reg <= pwdata[7:0];
                IDX_SC4: sc4_reg <= pwdata[7:0];
                IDX_CVH: cvh_reg <= pwdata[7:0];
                IDX_CVL: cvl_reg <= pwdata[7:0];
                IDX_PIN1: pin1_reg <= pwdata[7:0];
                IDX_PIN2: pin2_reg <= pwdata[7:0];
                IDX_IRQ_MASK: ev_mask_reg <= pwdata[1:0];
                default: ;
            endcase
        end
    end

    // first control register and done flag; set wins over clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sc1_reg <= SC1_RST;
        end else begin
            if (wr_sc1) begin
                sc1_reg[6:0] <= pwdata[6:0];
            end
            if (done_set) begin
                sc1_reg[SC1_DONE_BIT] <= 1'b1;
            end else if (wr_sc1 | rd_rl) begin
                sc1_reg[SC1_DONE_BIT] <= 1'b0;
            end
        end
    end

    // channel queue: push on write, flush on stop code
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q_cnt_reg <= 4'h0;
        end else if (wr_sc1 & ch_stop_wr) begin
            q_cnt_reg <= 4'h0;
        end else if (wr_sc1 & fifo_on & (q_cnt_reg < {1'b0, depth})) begin
            ch_q[q_cnt_reg[2:0]] <= pwdata[4:0];
            q_cnt_reg <= q_cnt_reg + 4'h1;
        end else if (done_now & set_last & fifo_on & ~cont) begin
            q_cnt_reg <= 4'h0; // single set used up
        end
    end

    // start pending: plain write arms, fifo arms when full
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            armed_reg <= 1'b0;
        end else if (wr_sc1) begin
            if (ch_stop_wr) begin
                armed_reg <= 1'b0;
            end else if (!fifo_on) begin
                armed_reg <= 1'b1;
            end else begin
                armed_reg <= (q_cnt_reg + 4'h1 == {1'b0, depth});
            end
        end else if (start_now) begin
            armed_reg <= 1'b0;
        end else if (done_now) begin
            armed_reg <= ~set_last | cont;
        end
    end

    // continuous run, set position, set compare memory
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cont_run_reg <= 1'b0;
            set_pos_reg <= 3'h0;
            set_hit_reg <= 1'b0;
        end else if (wr_sc1) begin
            cont_run_reg <= 1'b0;
            set_pos_reg <= 3'h0;
            set_hit_reg <= 1'b0;
        end else begin
            if (start_now & cont) begin
                cont_run_reg <= 1'b1;
            end
            if (done_now) begin
                set_pos_reg <= set_last ? 3'h0 : set_pos_reg + 3'h1;
                set_hit_reg <= set_last ? 1'b0 : (set_hit_reg | hit);
            end
        end
    end

    // sequencer: idle until armed and triggered, busy until done or an sc1 write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
        end else begin
            unique case (state_reg)
                ST_IDLE: if (start_now) state_reg <= ST_BUSY;
                ST_BUSY: if (wr_sc1 | conv_rsp.done) state_reg <= ST_IDLE;
            endcase
        end
    end

    // core request: start and abort pulses, channel routing
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            conv_req <= '{start: 1'b0, abort: 1'b0, channel: CH_STOP};
        end else begin
            conv_req.start <= start_now;
            conv_req.abort <= wr_sc1 & (state_reg == ST_BUSY);
            if (start_now) begin
                conv_req.channel <= fifo_on ? ch_q[set_pos_reg] : sc1_reg[4:0];
            end
        end
    end

    // result capture, right-justified
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            result_reg <= 12'h000;
            hw_prev_reg <= 1'b0;
        end else begin
            hw_prev_reg <= hw_trigger_input;
            if (done_now) begin
                result_reg <= conv_rsp.result;
            end
        end
    end

    // sticky events, cleared by reading; set wins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ev_stat_reg <= 2'h0;
        end else begin
            ev_stat_reg[EV_DONE] <= done_set | (ev_stat_reg[EV_DONE] & ~rd_stat);
            ev_stat_reg[EV_ABORT] <= (wr_sc1 & (state_reg == ST_BUSY)) |
                                     (ev_stat_reg[EV_ABORT] & ~rd_stat);
        end
    end

    // interrupt level
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= (sc1_reg[SC1_DONE_BIT] & sc1_reg[SC1_IEN_BIT]) | (|(ev_stat_reg & ev_mask_reg));
        end
    end

    // every property below samples on the rising clock and sleeps in reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // a software start: sc1 write with a real channel, no queue, no trigger wait
    sequence s_sc1_write_run;
        wr_sc1 && !ch_stop_wr && !fifo_on && !hw_mode;
    endsequence
    // a completion that nothing else touches in the same cycle
    sequence s_core_done;
        done_now && !sc1_reg[SC1_DONE_BIT] && !rd_rl;
    endsequence

    // the write aborts a running conversion at once
    AST_ABORT_ON_WRITE: assert property (wr_sc1 && state_reg == ST_BUSY |=>
        state_reg == ST_IDLE && conv_req.abort) else $error("busy write did not abort");
    // the write restarts two cycles later
    AST_RESTART: assert property (s_sc1_write_run ##1 !wr_sc1 [*2] |-> conv_req.start)
        else $error("write did not start a conversion");
    // each queue write lands one slot further
    AST_QUEUE_PUSH: assert property (wr_sc1 && fifo_on && !ch_stop_wr && q_cnt_reg < {1'b0, depth}
        |=> q_cnt_reg == $past(q_cnt_reg) + 4'h1) else $error("channel not queued");
    // nothing starts while the queue is short of its depth
    AST_NO_EARLY_START: assert property (fifo_on && q_cnt_reg < {1'b0, depth} |-> !start_now)
        else $error("started before queue filled");
    // the stop code empties the queue and halts
    AST_FLUSH: assert property (wr_sc1 && ch_stop_wr |=> q_cnt_reg == 4'h0 && !armed_reg
        && state_reg == ST_IDLE) else $error("stop code did not flush");
    // without compare or queue every completion flags
    AST_DONE_PLAIN: assert property (done_now && !sc2_reg[1] && !fifo_on
        |=> sc1_reg[SC1_DONE_BIT]) else $error("done flag missed");
    // with compare a false result leaves the flag clear
    AST_DONE_CMP: assert property (s_core_done and (sc2_reg[1] && !hit && !fifo_on)
        |=> !sc1_reg[SC1_DONE_BIT]) else $error("done set on false compare");
    // mid-set completions leave the flag clear
    AST_DONE_SET: assert property (s_core_done and (fifo_on && !set_last)
        |=> !sc1_reg[SC1_DONE_BIT]) else $error("done set mid set");
    // a write or low result read clears the flag
    AST_DONE_CLEAR: assert property ((wr_sc1 || rd_rl) && !done_set
        |=> !sc1_reg[SC1_DONE_BIT]) else $error("done flag not cleared");
    // flag with enable drives the interrupt next cycle
    AST_IRQ: assert property (sc1_reg[SC1_DONE_BIT] && sc1_reg[SC1_IEN_BIT] |=> irq)
        else $error("interrupt not raised");
    // a start makes the sequencer busy and pulses the core
    AST_ACTIVE: assert property (start_now |=> state_reg == ST_BUSY && conv_req.start)
        else $error("active flag not set");
    // a completion ends the busy span
    AST_IDLE_ON_DONE: assert property (done_now |=> state_reg == ST_IDLE)
        else $error("active flag not cleared");
    // the core gets the channel held in sc1 when no queue is used
    AST_ROUTE: assert property (start_now && !fifo_on |=> conv_req.channel == sc1_reg[4:0])
        else $error("wrong channel routed");
    // the result register takes the completed value
    AST_RESULT: assert property (done_now |=> result_reg == $past(conv_rsp.result))
        else $error("result not captured");
    // continuous mode arms the next conversion on completion
    AST_CONT_REARM: assert property (done_now && cont && !fifo_on |=> armed_reg)
        else $error("continuous run not rearmed");
    // hardware mode holds a first start until the trigger edge
    AST_HW_WAIT: assert property (hw_mode && !hw_edge && !cont_run_reg && set_pos_reg == 3'h0
        |-> !start_now) else $error("started without trigger");
    // the bus answers after exactly one wait state
    AST_ONE_WAIT: assert property (psel && penable && !pready |=> pready)
        else $error("bus answer late");

    // map_hit has no load: unmapped reads answer zero without an error
    logic unused_hit;
    assign unused_hit = map_hit;
endmodule : sar_converter_control

// File: tb/conv_core_model.sv
// conv_core_model: behavioural converter core facing the control block
// assumes one-cycle start and abort pulses, channel steady from start
`timescale 1ns/10ps
module conv_core_model
    import adc_ctrl_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // request, latency, answer
    input wire conv_req_t conv_req,
    input wire logic [7:0] lat,
    output conv_rsp_t conv_rsp
);
    logic [7:0] cnt_reg; // cycles left, zero when idle
    logic [4:0] ch_reg; // channel captured at start
    logic fire; // last cycle of a running conversion
    assign fire = rst_n & ~conv_req.start & ~conv_req.abort & (cnt_reg == 8'h01);
    // timer: start restarts, abort cancels
    always @(posedge clk) begin
        if (!rst_n) begin
            cnt_reg <= 8'h00;
            ch_reg <= 5'h00;
        end else if (conv_req.start) begin
            cnt_reg <= lat;
            ch_reg <= conv_req.channel;
        end else if (conv_req.abort) begin
            cnt_reg <= 8'h00;
        end else if (cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
        end
    end
    // answer: done pulse with the channel in the result; the lines wander otherwise
    always @(posedge clk) begin
        conv_rsp.done <= fire;
        if (!rst_n) begin
            conv_rsp.result <= 12'h000;
        end else if (fire) begin
            conv_rsp.result <= {ch_reg, 7'h2a};
        end else begin
            conv_rsp.result <= ~conv_rsp.result;
        end
    end
endmodule : conv_core_model

// File: tb/tb.sv
// tb: self-checking bench for the converter control block
// assumes the core model answers each start after lat cycles
`timescale 1ns/10ps
module tb
    import adc_ctrl_pkg::*;
;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, hw_trig = 0; // drives
    logic [17:0] paddr = '0; // byte address
    logic [31:0] pwdata = '0; // write data
    logic [31:0] prdata; // read data
    logic pready, pslverr, irq; // answers
    conv_req_t req; // to the core
    conv_rsp_t rsp; // from the core
    logic [7:0] lat = 8'h04; // core latency
    int errors = 0, n_compared = 0, aborts = 0; // counters
    logic [4:0] q[$]; // channels seen at start
    logic [15:0] ri [11] = '{IDX_SC1, IDX_SC2, IDX_SC3, IDX_SC4, IDX_RH, IDX_RL, IDX_CVH, IDX_CVL,
        IDX_PIN1, IDX_PIN2, 16'h0020}; // reset table
    // clock of 100 ns
    always #50 clk = ~clk;
    sar_converter_control #(.QDEPTH(8)) dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .conv_req(req), .conv_rsp(rsp), .hw_trigger_input(hw_trig), .irq(irq));
    conv_core_model core (.clk(clk), .rst_n(rst_n), .conv_req(req), .lat(lat), .conv_rsp(rsp));
    // record every start and abort
    always @(posedge clk) begin
        if (req.start === 1'b1) q.push_back(req.channel);
        if (req.abort === 1'b1) aborts++;
    end
    // compare and report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    // one apb transfer, held until pready
    task automatic xfer(input logic [15:0] i, input logic w, input logic [7:0] d, output logic [7:0] r);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk(pready, 1'b1, "pready");
        chk(pslverr, 1'b0, "slave error");
        r = prdata[7:0];
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [15:0] i, input logic [7:0] d);
        logic [7:0] t;
        xfer(i, 1'b1, d, t);
    endtask : wr
    // read and compare under a mask
    task automatic rdm(input logic [15:0] i, input logic [7:0] m, input logic [7:0] e, input string s);
        logic [7:0] t;
        xfer(i, 1'b0, 8'h00, t);
        chk(t & m, e, s);
    endtask : rdm
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    // poll the done flag, bounded
    task automatic wait_done();
        logic [7:0] t;
        int n;
        n = 0;
        do begin
            xfer(IDX_SC1, 1'b0, 8'h00, t);
            n++;
        end while (t[SC1_DONE_BIT] !== 1'b1 && n < 60);
        chk(t[SC1_DONE_BIT], 1'b1, "done flag");
    endtask : wait_done
    // expected result byte: channel on top, fixed low pattern
    function automatic logic [7:0] rres(input logic [4:0] c, input logic hi);
        logic [11:0] r;
        r = {c, 7'h2a};
        return hi ? {4'h0, r[11:8]} : r[7:0];
    endfunction : rres
    // verdict
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results
    // watchdog
    initial begin
        #(100 * 30000);
        errors++;
        results();
    end
    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 11; i++) rdm(ri[i], 8'hff, i == 0 ? SC1_RST : i == 1 ? SC2_RST : ZERO_RST, "reset");
        wr(IDX_RH, 8'hff);
        wr(16'h0020, 8'h55);
        rdm(IDX_RH, 8'hff, 8'h00, "read-only");
        rdm(16'h0020, 8'hff, 8'h00, "unmapped");
        wr(IDX_IRQ_MASK, 8'h03);
        rdm(IDX_IRQ_MASK, 8'hff, 8'h03, "mask");
        $display("test registers done");
        // single conversion with interrupt
        q.delete();
        wr(IDX_SC1, 8'h43);
        wait_done();
        chk(irq, 1'b1, "irq raised");
        chk(q.size(), 1, "one start");
        chk(q[0], 5'd3, "channel");
        rdm(IDX_RH, 8'hff, rres(5'd3, 1'b1), "result high");
        rdm(IDX_RL, 8'hff, rres(5'd3, 1'b0), "result low");
        rdm(IDX_IRQ_STAT, 8'h01, 8'h01, "done event");
        rdm(IDX_SC1, 8'hff, 8'h43, "done cleared by read");
        chk(irq, 1'b0, "irq cleared");
        $display("test single done");
        // abort by rewrite, then stop code
        lat <= 8'd40;
        q.delete();
        wr(IDX_SC1, 8'h04);
        cyc(8);
        rdm(IDX_SC2, 8'h80, 8'h80, "active");
        wr(IDX_SC1, 8'h05);
        wait_done();
        chk(aborts != 0, 1, "abort pulse");
        chk(q.size(), 2, "restart");
        rdm(IDX_IRQ_STAT, 8'h03, 8'h03, "abort and done events");
        rdm(IDX_RL, 8'hff, rres(5'd5, 1'b0), "new result");
        rdm(IDX_SC2, 8'h80, 8'h00, "inactive");
        wr(IDX_SC1, 8'h06);
        cyc(8);
        wr(IDX_SC1, {3'b000, CH_STOP});
        cyc(60);
        rdm(IDX_SC1, 8'hff, 8'h1f, "stopped");
        rdm(IDX_SC2, 8'h80, 8'h00, "aborted");
        $display("test abort done");
        // compare: greater-or-equal false, then less-than true
        lat <= 8'h04;
        wr(IDX_CVH, 8'h02);
        wr(IDX_CVL, 8'h00);
        wr(IDX_SC2, 8'h30);
        wr(IDX_SC1, 8'h03);
        cyc(30);
        rdm(IDX_SC1, 8'h80, 8'h00, "compare false");
        wr(IDX_SC2, 8'h20);
        wr(IDX_SC1, 8'h03);
        wait_done();
        wr(IDX_SC1, 8'h1f);
        rdm(IDX_SC1, 8'h80, 8'h00, "done cleared by write");
        wr(IDX_SC2, 8'h00);
        $display("test compare done");
        // fifo set of two channels
        lat <= 8'd20;
        wr(IDX_SC4, 8'h02);
        q.delete();
        wr(IDX_SC1, 8'h01);
        cyc(10);
        chk(q.size(), 0, "queue waits");
        wr(IDX_SC1, 8'h02);
        cyc(25);
        rdm(IDX_SC1, 8'h80, 8'h00, "set pending");
        wait_done();
        chk(q.size(), 2, "set size");
        chk(q[0], 5'd1, "order first");
        chk(q[1], 5'd2, "order second");
        // the same set repeated in a loop, then stopped
        lat <= 8'h04;
        q.delete();
        wr(IDX_SC1, 8'h28);
        wr(IDX_SC1, 8'h29);
        cyc(40);
        wr(IDX_SC1, 8'h1f);
        chk(q.size() >= 3, 1, "set loops");
        chk(q[2], 5'd8, "loop order");
        wr(IDX_SC4, 8'h00);
        $display("test fifo done");
        // continuous conversions, then stop
        lat <= 8'h04;
        q.delete();
        wr(IDX_SC1, 8'h26);
        cyc(60);
        chk(q.size() >= 3, 1, "repeats");
        wr(IDX_SC1, 8'h1f);
        cyc(10);
        q.delete();
        cyc(30);
        chk(q.size(), 0, "halted");
        $display("test continuous done");
        // hardware trigger
        wr(IDX_SC2, 8'h40);
        q.delete();
        wr(IDX_SC1, 8'h07);
        cyc(20);
        chk(q.size(), 0, "waits for trigger");
        hw_trig <= 1'b1;
        cyc(3);
        hw_trig <= 1'b0;
        wait_done();
        chk(q[0], 5'd7, "triggered");
        $display("test trigger done");
        results();
    end
endmodule : tb
